// ===== src/engine_protection_pkg.sv
// Constants shared by the engine protection monitor: timing, register map,
// field positions, reset values and anomaly-mask bit layout.
// Assumes a single 40 MHz clock domain.
package engine_protection_pkg;

  // Clock rate and the millisecond tick that all protection timers count.
  localparam int CLOCK_HZ = 40000000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_TIME_US;
  localparam int MS_PER_S = 1000;
  // Alive-message timeout for the message-driven engine family, in ms.
  localparam logic [15:0] ALIVE_TIMEOUT_MS = 16'h03e8;

  // Engine type codes that use the alive network-management message.
  localparam logic [7:0] ALIVE_TYPE_MIN = 8'h8c;
  localparam logic [7:0] ALIVE_TYPE_MAX = 8'h93;

  // Rated engine speeds in rpm for the two frequency ratings.
  localparam logic [15:0] RATED_RPM_50HZ = 16'h05dc;
  localparam logic [15:0] RATED_RPM_60HZ = 16'h0708;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ENGTYPE_OFS = 8'h04;
  localparam logic [7:0] COOLTHR_OFS = 8'h08;
  localparam logic [7:0] COOLDLY_OFS = 8'h0c;
  localparam logic [7:0] PUMPMAX_OFS = 8'h10;
  localparam logic [7:0] REGCOMM_OFS = 8'h14;
  localparam logic [7:0] ENGCOMM_OFS = 8'h18;
  localparam logic [7:0] SPDTHR_OFS = 8'h1c;
  localparam logic [7:0] SPDDLY_OFS = 8'h20;
  localparam logic [7:0] ANOMASK_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] INTMASK_OFS = 8'h2c;
  localparam logic [7:0] LIVE_OFS = 8'h30;

  // Control register fields.
  localparam int CTRL_PUMP_ASSIGNED = 0;
  localparam int CTRL_REG_PRESENT = 1;
  localparam int CTRL_RATED_60HZ = 2;
  // Communication registers: timeout in seconds low byte, action above it.
  localparam int ACTION_LSB = 8;

  // Status, mask and live-state bit positions.
  localparam int ST_LOW_COOL = 0;
  localparam int ST_PUMP_FAIL = 1;
  localparam int ST_REG_FAIL = 2;
  localparam int ST_ENG_FAIL = 3;
  localparam int ST_MIN_SPEED = 4;
  localparam int ST_CAN_WARN = 5;
  localparam int ST_CAN_ALARM = 6;
  localparam int ST_WIDTH = 7;

  // Anomaly-mask layout for engine-reported conditions.
  localparam logic [15:0] CAN_WARN_BITS = 16'h0a51;
  localparam logic [15:0] CAN_ALARM_BITS = 16'h04a2;
  localparam int RED_LAMP_BIT = 15;
  localparam int RED_AS_WARN_BIT = 13;

  // Reset values.
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Failure actions.
  typedef enum logic [1:0] {ACT_WARN, ACT_UNLOAD, ACT_DEACT, ACT_ALARM} action_e;

endpackage

// ===== src/engine_protection_monitor.sv
// Protection monitor: coolant, exhaust-fluid pump, link timeouts, minimum
// speed and engine-reported conditions, with a register port and interrupt.
// Assumes all inputs synchronous to clock and strobes one cycle long.
//
// Overview of operation
// - Coolant check armed only with analogue or CAN temperature measurement.
// - Warn when coolant stays below threshold for delay, engine stopped too.
// - Pump check armed only with pump output assigned and non-zero time.
// - Warn when pump output stays on for the maximum activation time.
// - On pump warning switch pump off; restart it once acknowledged.
// - Regulator failure when no regulator message for timeout; zero disables.
// - Regulator failure action: warning, unload, deactivation or alarm.
// - Types 140 to 147 need periodic alive message; missing means failure.
// - Other non-zero types fail when no engine message for silent time.
// - Engine failure action selectable; armed only for non-zero type.
// - Speed alarm armed with speed, fuel on, once in tolerance, not start/stop.
// - Speed alarm when speed stays below threshold for delay; zero disables.
// - Speed threshold is percent of 1500 rpm or 1800 rpm rating.
// - Engine-reported conditions armed only with non-zero engine type.
// - Mask bits 0,4,6,9,11 suppress matching engine-reported warnings.
// - Mask bits 1,5,7,10 suppress matching engine-reported alarms.
// - Mask bit 13 turns the red-lamp condition into a warning.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module engine_protection_monitor #(
  parameter int TICK_CYCLES = engine_protection_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wstrobe,
  input wire logic rstrobe,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic analogTempPresent,
  input wire logic [15:0] analogTemp,
  input wire logic canTempValid,
  input wire logic [15:0] canTemp,
  input wire logic pumpRequest,
  output logic pumpDrive,
  input wire logic regMsg,
  input wire logic engMsg,
  input wire logic engAliveMsg,
  input wire logic speedValid,
  input wire logic [15:0] speedRpm,
  input wire logic fuelSolenoid,
  input wire logic startStopPhase,
  input wire logic speedInTol,
  input wire logic [15:0] canCond,
  output logic lowCoolWarn,
  output logic pumpFailWarn,
  output logic regFail,
  output logic [1:0] regAction,
  output logic engFail,
  output logic [1:0] engAction,
  output logic minSpeedAlarm,
  output logic [15:0] engWarnings,
  output logic [15:0] engAlarms
);

  // One timer step: cleared whenever the watched condition is absent, else
  // counts ticks and parks at the limit so the fire flag holds.
  function automatic logic [15:0] stepTimer(input logic [15:0] cnt, input logic run,
                                            input logic tick, input logic [15:0] limit);
    if (!run) begin
      stepTimer = 16'h0;
    end else if (tick && cnt != limit) begin
      stepTimer = cnt + 16'h1;
    end else begin
      stepTimer = cnt;
    end
  endfunction

  // Minimum speed in rpm from the rating and a percentage.
  function automatic logic [15:0] minSpeed(input logic rated60, input logic [7:0] pct);
    logic [31:0] rated;
    rated = rated60 ? {16'h0, engine_protection_pkg::RATED_RPM_60HZ}
                    : {16'h0, engine_protection_pkg::RATED_RPM_50HZ};
    minSpeed = 16'((rated * {24'h0, pct}) / 32'd100);
  endfunction

  // Marks the millisecond tick that completes one second of a prescaler.
  function automatic logic secDone(input logic [15:0] ms, input logic tick);
    secDone = tick && ms == 16'(engine_protection_pkg::MS_PER_S - 1);
  endfunction

  logic [31:0] ctrl_reg;
  logic [7:0] engType_reg;
  logic [15:0] coolThr_reg, coolDly_reg, pumpMax_reg, spdDly_reg, anoMask_reg;
  logic [9:0] regComm_reg, engComm_reg;
  logic [7:0] spdPct_reg;
  // Status width, named here because many vectors below are sized by it.
  localparam int ST_WIDTH_L = engine_protection_pkg::ST_WIDTH;
  logic [ST_WIDTH_L-1:0] status_reg, status_next, intMask_reg, events;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [15:0] msCnt_reg, regMs_reg, engMs_reg;
  logic msTick_reg, regSec, engSec;
  logic [15:0] coolCnt_reg, pumpCnt_reg, regCnt_reg, engCnt_reg, spdCnt_reg;
  logic [15:0] coolCnt_next, pumpCnt_next, regCnt_next, engCnt_next, spdCnt_next;
  logic coolFire_reg, pumpFire_reg, regFire_reg, engFire_reg, spdFire_reg;
  logic pumpDrive_reg, inTolSeen_reg;
  logic [15:0] engWarn_reg, engAlarm_reg;
  logic [15:0] coolTemp, engLimit, spdThr;
  logic coolArmed, coolRun, pumpRun, regRun, engRun, spdArmed, spdRun, aliveType, engTick;
  logic wrHit;

  // Time base: the millisecond tick that every protection timer counts.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      msCnt_reg <= 16'h0;
      msTick_reg <= 1'b0;
    end else begin
      msTick_reg <= (msCnt_reg == 16'(TICK_CYCLES - 1));
      msCnt_reg <= (msCnt_reg == 16'(TICK_CYCLES - 1)) ? 16'h0 : msCnt_reg + 16'h1;
    end
  end

  // Each second timeout keeps its own millisecond count, restarted with its
  // condition. A shared second boundary would let a timeout fire after only a
  // moment of silence; this way silence must really last the whole time.
  always_ff @(posedge clock) begin
    if (!rst_n || !regRun) begin
      regMs_reg <= 16'h0;
    end else if (msTick_reg) begin
      regMs_reg <= regSec ? 16'h0 : regMs_reg + 16'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !engRun) begin
      engMs_reg <= 16'h0;
    end else if (msTick_reg) begin
      engMs_reg <= engSec ? 16'h0 : engMs_reg + 16'h1;
    end
  end

  // Arming and run conditions of each timed protection.
  always_comb begin
    coolArmed = analogTempPresent || (engType_reg != 8'h0 && canTempValid);
    coolTemp = analogTempPresent ? analogTemp : canTemp;
    coolRun = coolArmed && coolDly_reg != 16'h0 && coolTemp < coolThr_reg;
    pumpRun = ctrl_reg[engine_protection_pkg::CTRL_PUMP_ASSIGNED] && pumpMax_reg != 16'h0
              && pumpDrive_reg;
    regRun = ctrl_reg[engine_protection_pkg::CTRL_REG_PRESENT] && regComm_reg[7:0] != 8'h0
             && !regMsg;
    aliveType = engType_reg >= engine_protection_pkg::ALIVE_TYPE_MIN
                && engType_reg <= engine_protection_pkg::ALIVE_TYPE_MAX;
    engLimit = aliveType ? engine_protection_pkg::ALIVE_TIMEOUT_MS : {8'h0, engComm_reg[7:0]};
    regSec = secDone(regMs_reg, msTick_reg);
    engSec = secDone(engMs_reg, msTick_reg);
    engTick = aliveType ? msTick_reg : engSec;
    engRun = engType_reg != 8'h0 && engLimit != 16'h0
             && !(aliveType ? engAliveMsg : engMsg);
    spdArmed = speedValid && fuelSolenoid && inTolSeen_reg && !startStopPhase;
    spdThr = minSpeed(ctrl_reg[engine_protection_pkg::CTRL_RATED_60HZ], spdPct_reg);
    spdRun = spdArmed && spdDly_reg != 16'h0 && speedRpm < spdThr;
  end

  // Timer next values; a cleared condition restarts each from zero.
  always_comb begin
    coolCnt_next = stepTimer(coolCnt_reg, coolRun, msTick_reg, coolDly_reg);
    pumpCnt_next = stepTimer(pumpCnt_reg, pumpRun, msTick_reg, pumpMax_reg);
    regCnt_next = stepTimer(regCnt_reg, regRun, regSec, {8'h0, regComm_reg[7:0]});
    engCnt_next = stepTimer(engCnt_reg, engRun, engTick, engLimit);
    spdCnt_next = stepTimer(spdCnt_reg, spdRun, msTick_reg, spdDly_reg);
  end

  // Timers and fire flags; a fire flag needs a live condition and a full count.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      coolCnt_reg <= 16'h0;
      pumpCnt_reg <= 16'h0;
      regCnt_reg <= 16'h0;
      engCnt_reg <= 16'h0;
      spdCnt_reg <= 16'h0;
      coolFire_reg <= 1'b0;
      pumpFire_reg <= 1'b0;
      regFire_reg <= 1'b0;
      engFire_reg <= 1'b0;
      spdFire_reg <= 1'b0;
    end else begin
      coolCnt_reg <= coolCnt_next;
      pumpCnt_reg <= pumpCnt_next;
      regCnt_reg <= regCnt_next;
      engCnt_reg <= engCnt_next;
      spdCnt_reg <= spdCnt_next;
      coolFire_reg <= coolRun && coolCnt_next == coolDly_reg;
      pumpFire_reg <= pumpRun && pumpCnt_next == pumpMax_reg;
      regFire_reg <= regRun && regCnt_next == {8'h0, regComm_reg[7:0]};
      engFire_reg <= engRun && engCnt_next == engLimit;
      spdFire_reg <= spdRun && spdCnt_next == spdDly_reg;
    end
  end

  // The in-tolerance judgement is forgotten when the fuel command drops, so a
  // restart must reach tolerance again before the speed alarm can arm.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inTolSeen_reg <= 1'b0;
    end else if (!fuelSolenoid) begin
      inTolSeen_reg <= 1'b0;
    end else if (speedInTol && speedValid) begin
      inTolSeen_reg <= 1'b1;
    end
  end

  // Engine-reported conditions after the anomaly mask; red lamp follows bit 13.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      engWarn_reg <= 16'h0;
      engAlarm_reg <= 16'h0;
    end else if (engType_reg == 8'h0) begin
      engWarn_reg <= 16'h0;
      engAlarm_reg <= 16'h0;
    end else begin
      engWarn_reg <= canCond & ~anoMask_reg & engine_protection_pkg::CAN_WARN_BITS;
      engAlarm_reg <= canCond & ~anoMask_reg & engine_protection_pkg::CAN_ALARM_BITS;
      engWarn_reg[engine_protection_pkg::RED_LAMP_BIT] <=
        canCond[engine_protection_pkg::RED_LAMP_BIT]
        && anoMask_reg[engine_protection_pkg::RED_AS_WARN_BIT];
      engAlarm_reg[engine_protection_pkg::RED_LAMP_BIT] <=
        canCond[engine_protection_pkg::RED_LAMP_BIT]
        && !anoMask_reg[engine_protection_pkg::RED_AS_WARN_BIT];
    end
  end

  // Sticky status: events set, writing one clears, and a set beats a clear.
  always_comb begin
    events = '0;
    events[engine_protection_pkg::ST_LOW_COOL] = coolFire_reg;
    events[engine_protection_pkg::ST_PUMP_FAIL] = pumpFire_reg;
    events[engine_protection_pkg::ST_REG_FAIL] = regFire_reg;
    events[engine_protection_pkg::ST_ENG_FAIL] = engFire_reg;
    events[engine_protection_pkg::ST_MIN_SPEED] = spdFire_reg;
    events[engine_protection_pkg::ST_CAN_WARN] = |engWarn_reg;
    events[engine_protection_pkg::ST_CAN_ALARM] = |engAlarm_reg;
    wrHit = wstrobe && addr == engine_protection_pkg::STATUS_OFS;
    status_next = (status_reg & ~(wrHit ? wdata[ST_WIDTH_L-1:0] : '0)) | events;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & intMask_reg);
    end
  end

  // The pump stays off while its warning is unacknowledged; the request, and
  // so the chosen operating mode, is left untouched by the warning.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pumpDrive_reg <= 1'b0;
    end else begin
      pumpDrive_reg <= pumpRequest && !status_next[engine_protection_pkg::ST_PUMP_FAIL];
    end
  end

  // Configuration writes.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= engine_protection_pkg::CFG_RESET;
      engType_reg <= 8'h0;
      coolThr_reg <= 16'h0;
      coolDly_reg <= 16'h0;
      pumpMax_reg <= 16'h0;
      regComm_reg <= 10'h0;
      engComm_reg <= 10'h0;
      spdPct_reg <= 8'h0;
      spdDly_reg <= 16'h0;
      anoMask_reg <= 16'h0;
      intMask_reg <= '0;
    end else if (wstrobe) begin
      unique case (addr)
        engine_protection_pkg::CTRL_OFS: ctrl_reg <= {29'h0, wdata[2:0]};
        engine_protection_pkg::ENGTYPE_OFS: engType_reg <= wdata[7:0];
        engine_protection_pkg::COOLTHR_OFS: coolThr_reg <= wdata[15:0];
        engine_protection_pkg::COOLDLY_OFS: coolDly_reg <= wdata[15:0];
        engine_protection_pkg::PUMPMAX_OFS: pumpMax_reg <= wdata[15:0];
        engine_protection_pkg::REGCOMM_OFS: regComm_reg <= wdata[9:0];
        engine_protection_pkg::ENGCOMM_OFS: engComm_reg <= wdata[9:0];
        engine_protection_pkg::SPDTHR_OFS: spdPct_reg <= wdata[7:0];
        engine_protection_pkg::SPDDLY_OFS: spdDly_reg <= wdata[15:0];
        engine_protection_pkg::ANOMASK_OFS: anoMask_reg <= wdata[15:0];
        engine_protection_pkg::INTMASK_OFS: intMask_reg <= wdata[ST_WIDTH_L-1:0];
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock) begin
    if (!rst_n || !rstrobe) begin
      rdata_reg <= 32'h0;
    end else begin
      unique case (addr)
        engine_protection_pkg::CTRL_OFS: rdata_reg <= ctrl_reg;
        engine_protection_pkg::ENGTYPE_OFS: rdata_reg <= {24'h0, engType_reg};
        engine_protection_pkg::COOLTHR_OFS: rdata_reg <= {16'h0, coolThr_reg};
        engine_protection_pkg::COOLDLY_OFS: rdata_reg <= {16'h0, coolDly_reg};
        engine_protection_pkg::PUMPMAX_OFS: rdata_reg <= {16'h0, pumpMax_reg};
        engine_protection_pkg::REGCOMM_OFS: rdata_reg <= {22'h0, regComm_reg};
        engine_protection_pkg::ENGCOMM_OFS: rdata_reg <= {22'h0, engComm_reg};
        engine_protection_pkg::SPDTHR_OFS: rdata_reg <= {24'h0, spdPct_reg};
        engine_protection_pkg::SPDDLY_OFS: rdata_reg <= {16'h0, spdDly_reg};
        engine_protection_pkg::ANOMASK_OFS: rdata_reg <= {16'h0, anoMask_reg};
        engine_protection_pkg::STATUS_OFS: rdata_reg <= {25'h0, status_reg};
        engine_protection_pkg::INTMASK_OFS: rdata_reg <= {25'h0, intMask_reg};
        engine_protection_pkg::LIVE_OFS: rdata_reg <= {25'h0, |engAlarm_reg, |engWarn_reg,
                                                     spdFire_reg, engFire_reg, regFire_reg,
                                                     pumpFire_reg, coolFire_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  // Outputs straight from flip-flops.
  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign pumpDrive = pumpDrive_reg;
  assign lowCoolWarn = coolFire_reg;
  assign pumpFailWarn = status_reg[engine_protection_pkg::ST_PUMP_FAIL];
  assign regFail = regFire_reg;
  assign regAction = regComm_reg[engine_protection_pkg::ACTION_LSB +: 2];
  assign engFail = engFire_reg;
  assign engAction = engComm_reg[engine_protection_pkg::ACTION_LSB +: 2];
  assign minSpeedAlarm = spdFire_reg;
  assign engWarnings = engWarn_reg;
  assign engAlarms = engAlarm_reg;

  // Checks on the protections; all in the single clock domain.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_cool_arm: assert property (!coolArmed |=> !lowCoolWarn)
    else $error("Coolant warning without a temperature measurement.");
  chk_cool_fire: assert property ($rose(lowCoolWarn) |-> $past(coolRun) && $past(msTick_reg))
    else $error("Coolant warning without a full low-temperature delay.");
  chk_cool_disable: assert property (coolDly_reg == 16'h0 |=> !lowCoolWarn)
    else $error("Coolant warning with zero delay.");
  chk_pump_arm: assert property (pumpMax_reg == 16'h0 |=> !pumpFire_reg)
    else $error("Pump failure raised with a zero time.");
  chk_pump_off: assert property (pumpFailWarn |-> !pumpDrive)
    else $error("Pump driven while its failure warning stands.");
  chk_pump_restart: assert property ($fell(pumpFailWarn) && $past(pumpRequest) |-> pumpDrive)
    else $error("Pump not restarted after acknowledge.");
  chk_reg_disable: assert property (regComm_reg[7:0] == 8'h0 |=> !regFail)
    else $error("Regulator failure with check disabled.");
  chk_reg_restart: assert property (regMsg |=> !regFail)
    else $error("Regulator failure despite a fresh message.");
  chk_eng_arm: assert property (engType_reg == 8'h0 |=> !engFail && engWarnings == 16'h0)
    else $error("Engine failure or condition with no engine type.");
  chk_speed_disable: assert property (spdDly_reg == 16'h0 |=> !minSpeedAlarm)
    else $error("Minimum speed alarm with zero delay.");
  chk_speed_arm: assert property (!spdArmed |=> !minSpeedAlarm)
    else $error("Minimum speed alarm while not armed.");
  chk_can_mask: assert property ((engWarnings & $past(anoMask_reg)
                                  & engine_protection_pkg::CAN_WARN_BITS) == 16'h0)
    else $error("Masked engine warning passed through.");
  chk_red_lamp: assert property ($past(anoMask_reg[13]) |-> !engAlarms[15])
    else $error("Red lamp raised as alarm while set as warning.");

  cov_pump_fail: cover property ($rose(pumpFailWarn));
  cov_pump_ack: cover property ($fell(pumpFailWarn) ##1 pumpDrive);
  cov_eng_fail: cover property ($rose(engFail));
  cov_reg_fail: cover property ($rose(regFail));
  cov_speed_alarm: cover property ($rose(minSpeedAlarm));

endmodule

// ===== testbench/can_far_side.sv
// Far-side model: engine unit and voltage regulator message pulses over CAN.
// Assumes the monitor samples one-cycle message pulses on the same clock.
`timescale 1ns/1ps
module can_far_side #(
  parameter int PERIOD = 40
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic regTalk,
  input wire logic engTalk,
  input wire logic aliveTalk,
  output logic regMsg,
  output logic engMsg,
  output logic engAliveMsg
);
  logic [15:0] gap_reg;
  // Free-running message period; a silenced party just stops pulsing.
  always_ff @(posedge clock) begin
    if (!rst_n || gap_reg == PERIOD[15:0] - 16'h0001) begin
      gap_reg <= 16'h0000;
    end else begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  // Each message is one cycle long, so no pulse can be seen twice.
  always_ff @(posedge clock) begin
    regMsg <= rst_n && regTalk && gap_reg == 16'h0000;
    engMsg <= rst_n && engTalk && gap_reg == 16'h0000;
    engAliveMsg <= rst_n && aliveTalk && gap_reg == 16'h0000;
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the engine protection monitor.
// Assumes the far-side model can_far_side and a 40 MHz clock.
`timescale 1ns/1ps
module tb;
  localparam int TK = 4;
  logic clock, rst_n, wstrobe, rstrobe, irq, analogTempPresent, canTempValid, pumpRequest;
  logic pumpDrive, regMsg, engMsg, engAliveMsg, speedValid, fuelSolenoid, startStopPhase;
  logic speedInTol, lowCoolWarn, pumpFailWarn, regFail, engFail, minSpeedAlarm;
  logic regTalk, engTalk, aliveTalk;
  logic [1:0] regAction, engAction;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] analogTemp, canTemp, speedRpm, canCond, engWarnings, engAlarms;
  int nFail = 0;
  int comparisons = 0;

  // Short tick keeps second-long timeouts within a few thousand cycles.
  engine_protection_monitor #(.TICK_CYCLES(TK)) dut (.*);
  can_far_side #(.PERIOD(40)) far (.*);

  // Clock of 25 ns period.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Compare one value with its expectation and count the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait n edges, then step past them so registered outputs are settled.
  task automatic look(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    @(posedge clock);
    wstrobe <= 1'b0;
  endtask

  // One-cycle register read; data is only valid in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rstrobe <= 1'b1;
    @(posedge clock);
    rstrobe <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset values, unstored upper bits and an unmapped address.
  task automatic t_regs();
    rd(engine_protection_pkg::CTRL_OFS, 32'h0);
    wr(engine_protection_pkg::ENGTYPE_OFS, 32'h1ff);
    rd(engine_protection_pkg::ENGTYPE_OFS, 32'hff);
    wr(8'h34, 32'hffff);
    rd(8'h34, 32'h0);
    $display("regs done");
  endtask

  // A one-cycle gap in the cold condition must restart the delay.
  task automatic t_cool();
    wr(engine_protection_pkg::COOLTHR_OFS, 32'h64);
    wr(engine_protection_pkg::COOLDLY_OFS, 32'h5);
    wr(engine_protection_pkg::INTMASK_OFS, 32'h1);
    analogTempPresent <= 1'b1;
    analogTemp <= 16'h0032;
    look(3 * TK);
    @(posedge clock);
    analogTemp <= 16'h00c8;
    @(posedge clock);
    analogTemp <= 16'h0032;
    look(4 * TK - 2);
    check(lowCoolWarn, 32'h0);
    look(2 * TK + 3);
    check(lowCoolWarn, 32'h1);
    check(irq, 32'h1);
    @(posedge clock);
    analogTempPresent <= 1'b0;
    look(3);
    check(lowCoolWarn, 32'h0);
    wr(engine_protection_pkg::STATUS_OFS, 32'h1);
    look(2);
    check(irq, 32'h0);
    @(posedge clock);
    canTempValid <= 1'b1;
    canTemp <= 16'h0032;
    look(7 * TK);
    check(lowCoolWarn, 32'h1);
    @(posedge clock);
    canTempValid <= 1'b0;
    $display("coolant done");
  endtask

  // Pump held on too long is stopped, then restarted on acknowledge.
  task automatic t_pump();
    wr(engine_protection_pkg::CTRL_OFS, 32'h1);
    wr(engine_protection_pkg::PUMPMAX_OFS, 32'h3);
    wr(engine_protection_pkg::INTMASK_OFS, 32'h2);
    pumpRequest <= 1'b1;
    look(2 * TK - 2);
    check(pumpDrive, 32'h1);
    check(pumpFailWarn, 32'h0);
    look(2 * TK + 4);
    check(pumpFailWarn, 32'h1);
    check(pumpDrive, 32'h0);
    check(irq, 32'h1);
    wr(engine_protection_pkg::STATUS_OFS, 32'h2);
    look(1);
    check(pumpFailWarn, 32'h0);
    check(pumpDrive, 32'h1);
    wr(engine_protection_pkg::PUMPMAX_OFS, 32'h0);
    look(5 * TK);
    check(pumpFailWarn, 32'h0);
    @(posedge clock);
    pumpRequest <= 1'b0;
    $display("pump done");
  endtask

  // Both links go silent; then the alive-message family misses only alive.
  task automatic t_links();
    wr(engine_protection_pkg::ENGTYPE_OFS, 32'h1);
    wr(engine_protection_pkg::CTRL_OFS, 32'h2);
    wr(engine_protection_pkg::REGCOMM_OFS, 32'h301);
    wr(engine_protection_pkg::ENGCOMM_OFS, 32'h201);
    look(1010 * TK);
    check(regAction, 32'h3);
    check(engAction, 32'h2);
    check(regFail, 32'h0);
    check(engFail, 32'h0);
    regTalk <= 1'b0;
    engTalk <= 1'b0;
    aliveTalk <= 1'b0;
    look(980 * TK);
    check(regFail, 32'h0);
    check(engFail, 32'h0);
    look(30 * TK);
    check(regFail, 32'h1);
    check(engFail, 32'h1);
    wr(engine_protection_pkg::REGCOMM_OFS, 32'h0);
    wr(engine_protection_pkg::ENGTYPE_OFS, 32'h8c);
    engTalk <= 1'b1;
    look(1010 * TK);
    check(regFail, 32'h0);
    check(engFail, 32'h1);
    $display("links done");
  endtask

  // Engine-reported conditions through every mask bit and the red lamp.
  task automatic t_can();
    wr(engine_protection_pkg::ENGTYPE_OFS, 32'h1);
    canCond <= 16'hffff;
    look(3);
    check(engWarnings, engine_protection_pkg::CAN_WARN_BITS);
    check(engAlarms, engine_protection_pkg::CAN_ALARM_BITS | 16'h8000);
    wr(engine_protection_pkg::ANOMASK_OFS, 32'h2ef3);
    look(3);
    check(engWarnings, 32'h8000);
    check(engAlarms, 32'h0);
    wr(engine_protection_pkg::ENGTYPE_OFS, 32'h0);
    look(3);
    check(engWarnings, 32'h0);
    $display("can done");
  endtask

  // Threshold is 50 percent of 1500 or 1800 rpm; start phase holds it off.
  task automatic t_speed();
    wr(engine_protection_pkg::CTRL_OFS, 32'h0);
    wr(engine_protection_pkg::SPDTHR_OFS, 32'h32);
    wr(engine_protection_pkg::SPDDLY_OFS, 32'h3);
    speedValid <= 1'b1;
    fuelSolenoid <= 1'b1;
    speedInTol <= 1'b1;
    speedRpm <= 16'h02ed;
    @(posedge clock);
    speedInTol <= 1'b0;
    look(5 * TK);
    check(minSpeedAlarm, 32'h1);
    @(posedge clock);
    speedRpm <= 16'h02ee;
    look(3);
    check(minSpeedAlarm, 32'h0);
    wr(engine_protection_pkg::CTRL_OFS, 32'h4);
    speedRpm <= 16'h0383;
    look(5 * TK);
    check(minSpeedAlarm, 32'h1);
    @(posedge clock);
    startStopPhase <= 1'b1;
    look(3);
    check(minSpeedAlarm, 32'h0);
    $display("speed done");
  endtask

  // Main sequence: reset for 12 cycles, then every scenario in turn.
  initial begin
    {rst_n, wstrobe, rstrobe, analogTempPresent, canTempValid, pumpRequest} = '0;
    {speedValid, fuelSolenoid, startStopPhase, speedInTol} = '0;
    {addr, wdata, analogTemp, canTemp, speedRpm, canCond} = '0;
    {regTalk, engTalk, aliveTalk} = 3'h7;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_cool();
    t_pump();
    t_links();
    t_can();
    t_speed();
    report_and_stop();
  end

  // Watchdog: the scenarios need about 12500 cycles in all.
  initial begin
    repeat (30000) @(posedge clock);
    nFail++;
    report_and_stop();
  end
endmodule
